//--- rtl/aaf_consts.svh
`ifndef AAF_CONSTS_SVH
`define AAF_CONSTS_SVH
// ----------------------------------------
// opcode patterns
// ----------------------------------------
`define AAF_OP_ADD_IMM 8'h24
`define AAF_OP_ADD_DIR 8'h25
`define AAF_OP_ADD_IND 7'h13
`define AAF_OP_ADD_REG 5'h05
`define AAF_OP_ADD_WITH_CARRY_OP_IMM 8'h34
`define AAF_OP_ADD_WITH_CARRY_OP_DIR 8'h35
`define AAF_OP_ADD_WITH_CARRY_OP_IND 7'h1b
`define AAF_OP_ADD_WITH_CARRY_OP_REG 5'h07
// ----------------------------------------
// reset values
// ----------------------------------------
`define AAF_ACC_RST 8'h00
`define AAF_FLAG_RST 1'b0
// ----------------------------------------
// opcode fields
// ----------------------------------------
`define AAF_OP_MSB 7
`define AAF_OP_IND_LSB 1
`define AAF_OP_REG_LSB 3
`define AAF_OP_CARRY_BIT 4
`define AAF_OP_PTR_BIT 0
`define AAF_OP_SEL_MSB 2
`define AAF_OP_SEL_LSB 0
// ----------------------------------------
// carry positions in the partial sums
// ----------------------------------------
`define AAF_NIB_CY 4
`define AAF_LOW7_CY 7
`define AAF_BYTE_CY 8
// ----------------------------------------
// handled opcode ranges, for the decode checks
// ----------------------------------------
`define AAF_ADD_FIRST 8'h24
`define AAF_ADD_LAST 8'h2f
`define AAF_ADD_WITH_CARRY_OP_FIRST 8'h34
`define AAF_ADD_WITH_CARRY_OP_LAST 8'h3f
`endif

//--- rtl/aaf_pkg.sv
package aaf_pkg;
  typedef enum logic [2:0] {
    AAF_SRC_NONE = 3'h0,
    AAF_SRC_REG = 3'h1,
    AAF_SRC_DIR = 3'h2,
    AAF_SRC_IND = 3'h3,
    AAF_SRC_IMM = 3'h4
  } aaf_src_e;
endpackage

//--- rtl/aaf_alu.sv
`timescale 1ns/1ns
`default_nettype none
`include "aaf_consts.svh"
module aaf_alu
  import aaf_pkg::*;
(
  input wire logic core_clk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic exec_valid, // opcode and operands valid this cycle
  input wire logic [7:0] opcode, // instruction opcode
  input wire logic [7:0] operand_byte, // immediate or direct address byte
  input wire logic [7:0] reg_data, // selected working register value
  input wire logic [7:0] direct_data, // byte at direct address
  input wire logic [7:0] indirect_data, // byte pointed to by the pointer
  output logic [7:0] direct_addr, // direct address request
  output logic indirect_pointer_register, // pointer select, 0 or 1
  output logic [2:0] reg_sel, // working register select
  output logic op_accepted, // exec_valid high and opcode is a handled add
  output logic [7:0] acc, // accumulator
  output logic carry_flag, // carry
  output logic aux_carry_flag, // auxiliary carry
  output logic overflow_flag // overflow
);
  // ----------------------------------------
  // decode
  // ----------------------------------------
  function automatic aaf_src_e dec_src(input logic [7:0] op);
    if (op == `AAF_OP_ADD_IMM || op == `AAF_OP_ADD_WITH_CARRY_OP_IMM) begin
      dec_src = AAF_SRC_IMM;
    end else if (op == `AAF_OP_ADD_DIR || op == `AAF_OP_ADD_WITH_CARRY_OP_DIR) begin
      dec_src = AAF_SRC_DIR;
    end else if (op[`AAF_OP_MSB:`AAF_OP_IND_LSB] == `AAF_OP_ADD_IND ||
        op[`AAF_OP_MSB:`AAF_OP_IND_LSB] == `AAF_OP_ADD_WITH_CARRY_OP_IND) begin
      dec_src = AAF_SRC_IND;
    end else if (op[`AAF_OP_MSB:`AAF_OP_REG_LSB] == `AAF_OP_ADD_REG ||
        op[`AAF_OP_MSB:`AAF_OP_REG_LSB] == `AAF_OP_ADD_WITH_CARRY_OP_REG) begin
      dec_src = AAF_SRC_REG;
    end else begin
      dec_src = AAF_SRC_NONE;
    end
  endfunction

  aaf_src_e src;
  logic use_carry;
  logic [7:0] src_byte;
  logic [4:0] low_sum;
  logic [7:0] low7_sum;
  logic [8:0] full_sum;
  logic [7:0] acc_d, acc_q;
  logic cy_d, cy_q, ac_d, ac_q, ov_d, ov_q;

  always_comb begin
    src = dec_src(opcode);
    use_carry = opcode[`AAF_OP_CARRY_BIT]; // add with carry family
    direct_addr = operand_byte;
    indirect_pointer_register = opcode[`AAF_OP_PTR_BIT];
    reg_sel = opcode[`AAF_OP_SEL_MSB:`AAF_OP_SEL_LSB];
    op_accepted = exec_valid && (src != AAF_SRC_NONE);
    unique case (src)
      AAF_SRC_IMM: src_byte = operand_byte;
      AAF_SRC_DIR: src_byte = direct_data;
      AAF_SRC_IND: src_byte = indirect_data;
      AAF_SRC_REG: src_byte = reg_data;
      default: src_byte = 8'h00;
    endcase
  end

  // ----------------------------------------
  // adder and flags
  // ----------------------------------------
  // carries into bits 4 and 7 come from narrow partial sums, carry out from the full 9-bit sum, so each flag is exact
  always_comb begin
    logic cin;
    cin = use_carry & cy_q;
    low_sum = {1'b0, acc_q[3:0]} + {1'b0, src_byte[3:0]} + {4'h0, cin};
    low7_sum = {1'b0, acc_q[6:0]} + {1'b0, src_byte[6:0]} + {7'h00, cin};
    full_sum = {1'b0, acc_q} + {1'b0, src_byte} + {8'h00, cin};
    acc_d = acc_q;
    cy_d = cy_q;
    ac_d = ac_q;
    ov_d = ov_q;
    if (op_accepted) begin
      acc_d = full_sum[7:0];
      cy_d = full_sum[`AAF_BYTE_CY];
      ac_d = low_sum[`AAF_NIB_CY];
      ov_d = full_sum[`AAF_BYTE_CY] ^ low7_sum[`AAF_LOW7_CY];
    end
  end

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      acc_q <= `AAF_ACC_RST;
      cy_q <= `AAF_FLAG_RST;
      ac_q <= `AAF_FLAG_RST;
      ov_q <= `AAF_FLAG_RST;
    end else begin
      acc_q <= acc_d;
      cy_q <= cy_d;
      ac_q <= ac_d;
      ov_q <= ov_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign acc = acc_q;
  assign carry_flag = cy_q;
  assign aux_carry_flag = ac_q;
  assign overflow_flag = ov_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  ind_add_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    exec_valid && opcode[7:1] == `AAF_OP_ADD_IND |=>
    acc_q == 8'($past(acc_q) + $past(indirect_data)))
    else $error("indirect add result wrong");
  imm_add_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    exec_valid && opcode == `AAF_OP_ADD_IMM |=>
    acc_q == 8'($past(acc_q) + $past(operand_byte)))
    else $error("immediate add result wrong");
  dir_add_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    exec_valid && opcode == `AAF_OP_ADD_DIR |=>
    acc_q == 8'($past(acc_q) + $past(direct_data)))
    else $error("direct add result wrong");
  add_with_carry_op_sum_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    exec_valid && opcode == `AAF_OP_ADD_WITH_CARRY_OP_IMM |=>
    {cy_q, acc_q} == 9'($past(acc_q) + $past(operand_byte) + $past(cy_q)))
    else $error("add with carry result wrong");
  aux_carry_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    op_accepted && !use_carry |=>
    ac_q == (5'($past(acc_q[3:0]) + $past(src_byte[3:0])) > 5'h0f))
    else $error("aux carry wrong");
  ovf_sign_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    op_accepted |=> ov_q == (($past(acc_q[7]) == $past(src_byte[7]))
    && (acc_q[7] != $past(acc_q[7]))))
    else $error("overflow wrong");
  no_src_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    exec_valid && dec_src(opcode) == AAF_SRC_NONE |=> $stable(acc_q) && $stable(cy_q))
    else $error("unhandled opcode changed state");
  ptr_sel_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    src == AAF_SRC_IND |-> indirect_pointer_register ==
    (opcode == {`AAF_OP_ADD_IND, 1'b1} || opcode == {`AAF_OP_ADD_WITH_CARRY_OP_IND, 1'b1}))
    else $error("pointer select wrong");
  ind_accept_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    exec_valid && opcode[7:1] == `AAF_OP_ADD_IND |-> op_accepted)
    else $error("indirect add not taken in its own cycle");

  // ----------------------------------------
  // sum and flag checks
  // ----------------------------------------
  add_with_carry_op_src_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    op_accepted && use_carry |=>
    {cy_q, acc_q} == 9'($past(acc_q) + $past(src_byte) + $past(cy_q)))
    else $error("add with carry sum wrong");
  add_no_cin_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    op_accepted && !use_carry |=>
    {cy_q, acc_q} == 9'($past(acc_q) + $past(src_byte)))
    else $error("plain add sum or carry wrong");
  aux_cin_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    op_accepted && use_carry |=>
    ac_q == (5'($past(acc_q[3:0])) + 5'($past(src_byte[3:0])) + 5'($past(cy_q)) > 5'h0f))
    else $error("aux carry with carry in wrong");
  carry_out_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    op_accepted |=>
    cy_q == (9'($past(acc_q)) + 9'($past(src_byte)) + 9'($past(use_carry & cy_q))
    > 9'h0ff))
    else $error("carry flag wrong");
  ovf_mixed_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    op_accepted && (acc_q[7] != src_byte[7]) |=> !ov_q)
    else $error("overflow set for operands of unlike sign");
  add_with_carry_op_ind_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    exec_valid && opcode[7:1] == `AAF_OP_ADD_WITH_CARRY_OP_IND |=>
    {cy_q, acc_q} == 9'($past(acc_q) + $past(indirect_data) + $past(cy_q)))
    else $error("indirect add with carry result wrong");
  add_with_carry_op_dir_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    exec_valid && opcode == `AAF_OP_ADD_WITH_CARRY_OP_DIR |=>
    {cy_q, acc_q} == 9'($past(acc_q) + $past(direct_data) + $past(cy_q)))
    else $error("direct add with carry result wrong");
  add_with_carry_op_reg_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    exec_valid && opcode[7:3] == `AAF_OP_ADD_WITH_CARRY_OP_REG |=>
    {cy_q, acc_q} == 9'($past(acc_q) + $past(reg_data) + $past(cy_q)))
    else $error("register add with carry result wrong");
  reg_add_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    exec_valid && opcode[7:3] == `AAF_OP_ADD_REG |=>
    acc_q == 8'($past(acc_q) + $past(reg_data)))
    else $error("register add result wrong");

  // ----------------------------------------
  // decode and hold checks
  // ----------------------------------------
  // refused opcodes and idle cycles must leave every flag as it was
  accept_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    op_accepted == (exec_valid && (opcode inside {[`AAF_ADD_FIRST:`AAF_ADD_LAST],
    [`AAF_ADD_WITH_CARRY_OP_FIRST:`AAF_ADD_WITH_CARRY_OP_LAST]})))
    else $error("accepted opcode set wrong");
  idle_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !op_accepted |=>
    $stable(acc_q) && $stable(cy_q) && $stable(ac_q) && $stable(ov_q))
    else $error("state changed without an accepted add");

  // ----------------------------------------
  // reset checks
  // ----------------------------------------
  // no disable here, so a register that misses reset shows up
  rst_clear_a: assert property (@(posedge core_clk)
    !rst_n |=>
    acc_q == `AAF_ACC_RST && cy_q == `AAF_FLAG_RST && ac_q == `AAF_FLAG_RST
    && ov_q == `AAF_FLAG_RST)
    else $error("reset left accumulator or flags set");
endmodule // aaf_alu
`default_nettype wire

//--- test/aaf_alu_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin miscompares++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module aaf_alu_tb_top;
  import aaf_pkg::*;
  typedef struct packed {logic v; logic [7:0] op; logic [7:0] s; logic [7:0] a; logic [3:0] f;}
    aaf_row_s;
  // f holds accepted, carry, aux carry, overflow; rows chain through acc and carry
  localparam aaf_row_s ROWS [13] = '{
    '{1'b1, 8'h24, 8'h3A, 8'h3A, 4'h8}, '{1'b1, 8'h25, 8'hC9, 8'h03, 4'hE},
    '{1'b1, 8'h34, 8'h7F, 8'h83, 4'hB}, '{1'b1, 8'h26, 8'h80, 8'h03, 4'hD},
    '{1'b1, 8'h37, 8'h10, 8'h14, 4'h8}, '{1'b1, 8'h35, 8'hEB, 8'hFF, 4'h8},
    '{1'b1, 8'h3A, 8'h01, 8'h00, 4'hE}, '{1'b1, 8'h2F, 8'h0F, 8'h0F, 4'h8},
    '{1'b1, 8'h36, 8'h08, 8'h17, 4'hA}, '{1'b1, 8'h33, 8'hFF, 8'h17, 4'h2},
    '{1'b0, 8'h24, 8'hFF, 8'h17, 4'h2}, '{1'b1, 8'h38, 8'h70, 8'h87, 4'h9},
    '{1'b1, 8'h27, 8'h79, 8'h00, 4'hE}};
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic exec_valid = 1'b0;
  logic [7:0] opcode = 8'h00, operand_byte = 8'h00, reg_data = 8'h00;
  logic [7:0] direct_data = 8'h00, indirect_data = 8'h00, direct_addr, acc;
  logic indirect_pointer_register, op_accepted, carry_flag, aux_carry_flag, overflow_flag;
  logic [2:0] reg_sel;
  int miscompares = 0;
  int checks = 0;
  aaf_alu DUT (.core_clk(core_clk), .rst_n(rst_n), .exec_valid(exec_valid), .opcode(opcode),
    .operand_byte(operand_byte), .reg_data(reg_data), .direct_data(direct_data),
    .indirect_data(indirect_data), .direct_addr(direct_addr),
    .indirect_pointer_register(indirect_pointer_register), .reg_sel(reg_sel),
    .op_accepted(op_accepted), .acc(acc), .carry_flag(carry_flag),
    .aux_carry_flag(aux_carry_flag), .overflow_flag(overflow_flag));
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // unselected direct, indirect and register sources carry the inverse, an unselected immediate 8'h5A, so a wrong mux shows up
  task automatic drive(input aaf_row_s r);
    exec_valid = r.v;
    opcode = r.op;
    operand_byte = (r.op[3:0] == 4'h4) ? r.s : 8'h5A;
    direct_data = (r.op[3:0] == 4'h5) ? r.s : ~r.s;
    indirect_data = (r.op[3:1] == 3'h3) ? r.s : ~r.s;
    reg_data = r.op[3] ? r.s : ~r.s;
  endtask
  task automatic check_state(input logic [7:0] a, input logic [2:0] f);
    `CHK("acc", a, acc)
    `CHK("flags", f, {carry_flag, aux_carry_flag, overflow_flag})
  endtask
  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge core_clk);
    #2 rst_n = 1'b1;
    check_state(8'h00, 3'h0);
    foreach (ROWS[i]) begin
      drive(ROWS[i]);
      #1;
      `CHK("op_accepted", ROWS[i].f[3], op_accepted)
      `CHK("direct_addr", operand_byte, direct_addr)
      `CHK("pointer", ROWS[i].op[0], indirect_pointer_register)
      `CHK("reg_sel", ROWS[i].op[2:0], reg_sel)
      @(posedge core_clk);
      #2 check_state(ROWS[i].a, ROWS[i].f[2:0]);
    end
    // reset in mid-run wins over a valid add
    drive('{1'b1, 8'h24, 8'h11, 8'h00, 4'h8});
    rst_n = 1'b0;
    @(posedge core_clk);
    #2 check_state(8'h00, 3'h0);
    rst_n = 1'b1;
    @(posedge core_clk);
    #2 check_state(8'h11, 3'h0);
    exec_valid = 1'b0;
    complete_run();
  end
endmodule // aaf_alu_tb_top
`default_nettype wire
